// ---- rtl/reset_cause_and_clock_config.sv ----
// Reset-cause log, run-mode clock configuration, gating select and interrupt logic
// Assumes a classic Wishbone master, pll_tick and osc_tick as enables on clk,
// and rst_b asserted only at power-up of this block.
//
// Functional notes
// R1 - External pin reset sets pin cause and clears all other cause bits.
// R2 - Other resets set their cause bit and keep earlier causes.
// R3 - Bit 5 regulator loss, bit 4 software, bit 3 watchdog.
// R4 - Bit 2 brown-out, bit 1 power-on, bit 0 external pin.
// R5 - Six cause bits read/write; bits 31:6 reserved, read as zero.
// R6 - Auto gating set: sleep and deep-sleep use their own gating sets.
// R7 - Auto gating clear: run gating set stays in force while sleeping.
// R8 - In run mode only the run gating set controls clocks.
// R9 - Divisor field 26:23 resets to 0xF, ratio code plus one.
// R10 - With PLL, divide 200 MHz output; codes below 0011 not allowed.
// R11 - PLL not bypassed: PLL divided; bypassed: oscillator source.
// R12 - Codes below PLL minimum take effect on non-PLL source.
// R13 - Software write replaces the six cause bits.
`include "rcfg_defines.svh"

module reset_cause_and_clock_config
  import rcfg_pkg::*;
#(
  parameter int GATE_W = 32
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              pin_reset_req,
  input  wire logic              brownout_req,
  input  wire logic              watchdog_req,
  input  wire logic              software_req,
  input  wire logic              regulator_loss_req,
  input  wire logic              pll_tick,
  input  wire logic              osc_tick,
  input  wire logic [2:0]        power_mode,
  input  wire logic [GATE_W-1:0] run_gating_regs,
  input  wire logic [GATE_W-1:0] sleep_gating_regs,
  input  wire logic [GATE_W-1:0] deep_sleep_gating_regs,
  output logic      [GATE_W-1:0] periph_clk_en,
  output logic                   sys_tick,
  output logic                   irq
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Raise a code to the PLL minimum while the PLL feeds the system
  function automatic logic [3:0] effective_code(
    input logic [3:0] code,
    input logic       pll_used
  );
    effective_code = code;
    if (pll_used && (code < `RCFG_MIN_DIV)) begin
      effective_code = `RCFG_MIN_DIV;
    end
  endfunction

  // Write-one-to-clear with set winning over clear
  function automatic cause_t sticky_next(
    input cause_t cur,
    input cause_t clr,
    input cause_t set
  );
    sticky_next = (cur & ~clr) | set;
  endfunction

  // Word match on address bits 7:2, byte lanes ignored
  function automatic logic reg_hit(
    input logic [7:0] adr,
    input logic [7:0] ofs
  );
    reg_hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // ****************************************************************
  // Bus decode
  // ****************************************************************

  logic        ack_q;
  logic [31:0] rdata_q;

  // Held request taken once; ack_q blocks a retake
  wire req      = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr       = req & wb_we_i;
  wire rd_req   = req & ~wb_we_i;
  wire hit_log  = reg_hit(wb_adr_i, `RCFG_LOG_OFS);
  wire hit_rcc  = reg_hit(wb_adr_i, `RCFG_RCC_OFS);
  wire hit_st   = reg_hit(wb_adr_i, `RCFG_IRQ_ST_OFS);
  wire hit_msk  = reg_hit(wb_adr_i, `RCFG_IRQ_MSK_OFS);
  wire hit_src  = reg_hit(wb_adr_i, `RCFG_SRC_OFS);

  wire wr_log   = wr & hit_log & wb_sel_i[0];
  wire wr_st    = wr & hit_st & wb_sel_i[0];
  wire wr_msk   = wr & hit_msk & wb_sel_i[0];
  wire wr_src   = wr & hit_src & wb_sel_i[0];
  wire wr_rcc_h = wr & hit_rcc & wb_sel_i[3];
  wire wr_rcc_m = wr & hit_rcc & wb_sel_i[2];

  // ****************************************************************
  // Cause events
  // ****************************************************************

  logic [4:0] ext_ev;
  logic       por_pend_q;
  cause_t     ev;

  cause_capture #(
    .N (5)
  ) u_capture (
    .clk         (clk),
    .rst_b       (rst_b),
    .req_async   ({regulator_loss_req, software_req, watchdog_req,
                   brownout_req, pin_reset_req}),
    .event_pulse (ext_ev)
  );

  // Power-on cause is reported once, right after release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      por_pend_q <= 1'b1;
    end else begin
      por_pend_q <= 1'b0;
    end
  end

  always_comb begin
    ev                 = '0;
    ev[`RCFG_PIN_BIT]  = ext_ev[0];
    ev[`RCFG_POR_BIT]  = por_pend_q;
    ev[`RCFG_BOR_BIT]  = ext_ev[1];
    ev[`RCFG_WDT_BIT]  = ext_ev[2];
    ev[`RCFG_SWR_BIT]  = ext_ev[3];
    ev[`RCFG_REG_BIT]  = ext_ev[4];
  end

  // ****************************************************************
  // Reset cause log
  // ****************************************************************

  cause_t log_q;
  cause_t log_d;
  cause_t log_base;

  // Software value first, hardware causes on top
  assign log_base = wr_log ? wb_dat_i[5:0] : log_q;   // [R13] [R5]

  always_comb begin
    if (ev[`RCFG_PIN_BIT]) begin
      log_d = ev;                                      // [R1]
    end else begin
      log_d = log_base | ev;                           // [R2] [R3] [R4]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      log_q <= '0;
    end else begin
      log_q <= log_d;
    end
  end

  // ****************************************************************
  // Run-mode clock configuration
  // ****************************************************************

  logic       acg_q;
  logic [3:0] div_q;
  logic       usediv_q;
  logic       bypass_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acg_q    <= 1'b0;
      div_q    <= `RCFG_DIV_RST;                       // [R9]
      usediv_q <= 1'b0;
    end else begin
      if (wr_rcc_h) begin
        acg_q     <= wb_dat_i[`RCFG_ACG_BIT];
        div_q[3:1] <= wb_dat_i[`RCFG_DIV_MSB:`RCFG_DIV_LSB+1];
      end
      if (wr_rcc_m) begin
        div_q[0] <= wb_dat_i[`RCFG_DIV_LSB];
        usediv_q <= wb_dat_i[`RCFG_USEDIV_BIT];
      end
    end
  end

  // Oscillator source after reset, PLL once software clears it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bypass_q <= `RCFG_BYPASS_RST;
    end else if (wr_src) begin
      bypass_q <= wb_dat_i[`RCFG_BYPASS_BIT];
    end
  end

  // ****************************************************************
  // System clock source and divisor
  // ****************************************************************

  wire       pll_used = ~bypass_q;
  wire [3:0] eff_div  = effective_code(div_q, pll_used);      // [R10] [R12]
  wire       src_tick = pll_used ? pll_tick : osc_tick;       // [R11]
  wire       apply_div = pll_used | usediv_q;
  wire [3:0] ratio_code = apply_div ? eff_div : 4'h0;         // [R9] [R11]

  sysclk_divider u_divider (
    .clk      (clk),
    .rst_b    (rst_b),
    .src_tick (src_tick),
    .div_code (ratio_code),
    .sys_tick (sys_tick)
  );

  // ****************************************************************
  // Peripheral clock gating select
  // ****************************************************************

  logic [GATE_W-1:0] gate_d;

  always_comb begin
    unique case (power_mode)
      PM_RUN: begin
        gate_d = run_gating_regs;                     // [R8]
      end
      PM_SLEEP: begin
        gate_d = acg_q ? sleep_gating_regs : run_gating_regs;      // [R6] [R7]
      end
      PM_DEEP: begin
        gate_d = acg_q ? deep_sleep_gating_regs : run_gating_regs; // [R6] [R7]
      end
      default: begin
        gate_d = run_gating_regs;
      end
    endcase
  end

  // Registered so a mode change reaches the gates on a clean edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      periph_clk_en <= '0;
    end else begin
      periph_clk_en <= gate_d;
    end
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************

  cause_t st_q;
  cause_t msk_q;
  cause_t st_clr;
  cause_t st_d;
  cause_t msk_d;

  assign st_clr = wr_st ? wb_dat_i[5:0] : '0;
  // Set wins over a same-cycle clear
  assign st_d   = sticky_next(st_q, st_clr, ev);
  assign msk_d  = wr_msk ? wb_dat_i[5:0] : msk_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q  <= '0;
      msk_q <= '0;
    end else begin
      st_q  <= st_d;
      msk_q <= msk_d;
    end
  end

  // Built from next values so irq tracks status with no lag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(st_d & msk_d);
    end
  end

  // ****************************************************************
  // Read data and acknowledge
  // ****************************************************************

  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_log) begin
      rdata_d[5:0] = log_q;                           // [R5]
    end
    if (hit_rcc) begin
      rdata_d[`RCFG_ACG_BIT]                  = acg_q;
      rdata_d[`RCFG_DIV_MSB:`RCFG_DIV_LSB]    = eff_div;   // [R10]
      rdata_d[`RCFG_USEDIV_BIT]               = usediv_q;
    end
    if (hit_st) begin
      rdata_d[5:0] = st_q;
    end
    if (hit_msk) begin
      rdata_d[5:0] = msk_q;
    end
    if (hit_src) begin
      rdata_d[`RCFG_BYPASS_BIT] = bypass_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Read data held until the next read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_req) begin
      rdata_q <= rdata_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

endmodule

// ---- inc/rcfg_defines.svh ----
// Offsets, field positions, reset values and limits of the reset-cause and clock-configuration block
// Assumes byte addresses on an 8-bit Wishbone address, 32-bit data
`ifndef RCFG_DEFINES_SVH
`define RCFG_DEFINES_SVH

`define RCFG_LOG_OFS      8'h5C
`define RCFG_RCC_OFS      8'h60
`define RCFG_IRQ_ST_OFS   8'h70
`define RCFG_IRQ_MSK_OFS  8'h74
`define RCFG_SRC_OFS      8'h78

`define RCFG_CAUSE_W      6
`define RCFG_PIN_BIT      0
`define RCFG_POR_BIT      1
`define RCFG_BOR_BIT      2
`define RCFG_WDT_BIT      3
`define RCFG_SWR_BIT      4
`define RCFG_REG_BIT      5

`define RCFG_ACG_BIT      27
`define RCFG_DIV_MSB      26
`define RCFG_DIV_LSB      23
`define RCFG_USEDIV_BIT   22
`define RCFG_DIV_RST      4'hF
`define RCFG_MIN_DIV      4'h3
`define RCFG_BYPASS_BIT   0
`define RCFG_BYPASS_RST   1'b1

`endif

// ---- inc/rcfg_pkg.sv ----
// Types shared by the reset-cause and clock-configuration block
// Assumes nothing beyond SystemVerilog packages
package rcfg_pkg;

  typedef enum logic [2:0] {
    PM_RUN   = 3'b001,
    PM_SLEEP = 3'b010,
    PM_DEEP  = 3'b100
  } power_mode_e;

  typedef logic [5:0] cause_t;

endpackage

// ---- rtl/cause_capture.sv ----
// Synchroniser and rising-edge detector for asynchronous reset-cause requests
// Assumes each request is a level held for at least three clock cycles
module cause_capture #(
  parameter int N = 5
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [N-1:0] req_async,
  output logic      [N-1:0] event_pulse
);

  logic [N-1:0] s1_q;
  logic [N-1:0] s2_q;
  logic [N-1:0] s3_q;
  logic [N-1:0] stable_q;

  wire  [N-1:0] agree = ~(s2_q ^ s3_q);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q     <= '0;
      s2_q     <= '0;
      s3_q     <= '0;
      stable_q <= '0;
    end else begin
      s1_q     <= req_async;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      stable_q <= (agree & s3_q) | (~agree & stable_q);
    end
  end

  // One pulse when an agreed level first turns high
  assign event_pulse = agree & s3_q & ~stable_q;

endmodule

// ---- rtl/sysclk_divider.sv ----
// Divider turning source-clock enable ticks into system-clock enable ticks
// Assumes src_tick is a one-cycle enable pulse on clk
module sysclk_divider (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       src_tick,
  input  wire logic [3:0] div_code,
  output logic            sys_tick
);

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic       tick_d;

  // Ratio is code plus one; a shrunken code restarts the count
  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (cnt_q > div_code) begin
      cnt_d = 4'h0;
    end else if (src_tick) begin
      if (cnt_q == div_code) begin
        cnt_d  = 4'h0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q    <= 4'h0;
      sys_tick <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      sys_tick <= tick_d;
    end
  end

endmodule

// ---- verification/rcfg_chk.sv ----
// Port checker of the reset-cause and clock-configuration block
// Assumes the top module's port names; bound at the foot of this file
module rcfg_chk
  import rcfg_pkg::*;
#(
  parameter int GATE_W = 32
) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [7:0]        wb_adr_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              pll_tick,
  input wire logic              osc_tick,
  input wire logic [2:0]        power_mode,
  input wire logic [GATE_W-1:0] run_gating_regs,
  input wire logic [GATE_W-1:0] sleep_gating_regs,
  input wire logic [GATE_W-1:0] deep_sleep_gating_regs,
  input wire logic [GATE_W-1:0] periph_clk_en,
  input wire logic              sys_tick
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_RUN_GATE:
    assert property (rst_b && power_mode == 3'h1 |=> periph_clk_en == $past(run_gating_regs))
      else $error("run gating vector not applied");
  AST_SLEEP_GATE:
    assert property (power_mode == 3'h2 |=> periph_clk_en == $past(run_gating_regs)
      || periph_clk_en == $past(sleep_gating_regs)) else $error("sleep gating vector wrong");
  AST_DEEP_GATE:
    assert property (power_mode == 3'h4 |=> periph_clk_en == $past(run_gating_regs)
      || periph_clk_en == $past(deep_sleep_gating_regs)) else $error("deep gating vector wrong");
  AST_TICK_SRC:
    assert property (sys_tick |-> $past(pll_tick) || $past(osc_tick))
      else $error("system tick without source tick");
  AST_ACK_RESP:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered");
  AST_ACK_PULSE:
    assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
  AST_LOG_RSV:
    assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h5C |-> wb_dat_o[31:6] == 26'h0)
      else $error("cause log upper bits not zero");
  AST_RCC_RSV:
    assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h60
      |-> wb_dat_o[31:28] == 4'h0 && wb_dat_o[21:0] == 22'h0) else $error("clock config spare bits set");
endmodule

bind reset_cause_and_clock_config rcfg_chk #(
  .GATE_W (GATE_W)
) rcfg_chk_i (
  .clk                    (clk),
  .rst_b                  (rst_b),
  .wb_cyc_i               (wb_cyc_i),
  .wb_stb_i               (wb_stb_i),
  .wb_we_i                (wb_we_i),
  .wb_adr_i               (wb_adr_i),
  .wb_dat_o               (wb_dat_o),
  .wb_ack_o               (wb_ack_o),
  .pll_tick               (pll_tick),
  .osc_tick               (osc_tick),
  .power_mode             (power_mode),
  .run_gating_regs        (run_gating_regs),
  .sleep_gating_regs      (sleep_gating_regs),
  .deep_sleep_gating_regs (deep_sleep_gating_regs),
  .periph_clk_en          (periph_clk_en),
  .sys_tick               (sys_tick)
);

// ---- verification/testbench.sv ----
// Self-checking bench of the reset-cause and clock-configuration block
// Assumes package, defines, design and checker compiled before it
module testbench
  import rcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst_b, cyc, stb, we, ack, irq, tick;
  logic        pll = 1'b0, osc = 1'b0;
  logic [1:0]  ph = 2'h0;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [4:0]  req;
  logic [2:0]  pm;
  logic [31:0] dw, dr, rd, rg, sg, dg, en;
  int          error_cnt = 0, checks = 0, cyc_cnt = 0;

  reset_cause_and_clock_config reset_cause_and_clock_config_i (
    .clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .pin_reset_req(req[0]),
    .brownout_req(req[1]), .watchdog_req(req[2]), .software_req(req[3]), .regulator_loss_req(req[4]),
    .pll_tick(pll), .osc_tick(osc), .power_mode(pm), .run_gating_regs(rg), .sleep_gating_regs(sg),
    .deep_sleep_gating_regs(dg), .periph_clk_en(en), .sys_tick(tick), .irq(irq));

  // ****************************************
  // Clock, timeout and shared tasks
  // ****************************************
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    // PLL tick every second cycle, oscillator every fourth, one idle cycle
    ph  <= ph + 2'h1;
    pll <= ph[0];
    osc <= (ph == 2'h2);
    if (cyc_cnt == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done();
    if (error_cnt == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    sel <= s;
    dw <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dr;
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(0, a, 32'h0);
    chk(rd, e, nm);
  endtask

  // Cause request held long enough for the synchroniser
  task automatic fire(input int b);
    req[b] <= 1;
    repeat (5) @(posedge clk);
    req[b] <= 0;
    repeat (2) @(posedge clk);
  endtask

  task automatic ratio(input int r);
    int n = 0;
    repeat (2) do @(posedge clk); while (tick !== 1'b1);
    repeat (64) begin
      @(posedge clk);
      n += tick;
    end
    chk(n, 64 / r, "ticks");
  endtask

  task automatic gate(input logic [2:0] m, input logic [31:0] e);
    pm <= m;
    repeat (2) @(posedge clk);
    chk(en, e, "gating");
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rchk(8'h5C, 32'h2, "log");
    rchk(8'h60, 32'h0780_0000, "rcc");
    rchk(8'h78, 32'h1, "source");
    rchk(8'h40, 32'h0, "unmapped");
  endtask

  task automatic t_causes();
    logic [31:0] exp [6] = '{32'hA, 32'hE, 32'h1E, 32'h3E, 32'h1, 32'h5};
    int          src [6] = '{2, 1, 3, 4, 0, 1};
    for (int i = 0; i < 6; i++) begin
      fire(src[i]);
      rchk(8'h5C, exp[i], "log");
    end
    wr(8'h5C, 32'hFFFF_FF24);
    rchk(8'h5C, 32'h24, "log");
  endtask

  task automatic t_irq();
    wr(8'h70, 32'h3F);
    wr(8'h74, 32'h8);
    chk(irq, 32'h0, "irq idle");
    fire(2);
    chk(irq, 32'h1, "irq set");
    rchk(8'h70, 32'h8, "status");
    wr(8'h70, 32'h8);
    chk(irq, 32'h0, "irq cleared");
    fire(1);
    chk(irq, 32'h0, "irq masked");
  endtask

  task automatic t_gate();
    gate(PM_RUN, rg);
    gate(PM_SLEEP, rg);
    gate(PM_DEEP, rg);
    wr(8'h60, 32'h0F80_0000);
    gate(PM_SLEEP, sg);
    gate(PM_DEEP, dg);
    gate(3'h6, rg);
    gate(PM_RUN, rg);
  endtask

  task automatic t_div();
    wr(8'h78, 32'h0);
    ratio(32);
    wr(8'h60, 32'h0);
    rchk(8'h60, 32'h0180_0000, "rcc");
    ratio(8);
    wr(8'h78, 32'h1);
    rchk(8'h60, 32'h0, "rcc");
    wr(8'h60, 32'h0080_0000);
    ratio(4);
    wr(8'h60, 32'h00C0_0000);
    ratio(8);
    bus(1, 8'h60, 32'h0F80_0000, 4'h8);
    rchk(8'h60, 32'h0FC0_0000, "rcc bytes");
  endtask

  initial begin
    rst_b = 0;
    cyc = 0;
    stb = 0;
    we = 0;
    adr = 8'h0;
    sel = 4'h0;
    dw = 32'h0;
    req = 5'h0;
    pm = PM_RUN;
    rg = 32'hA5A5_0001;
    sg = 32'h5A5A_0002;
    dg = 32'h3C3C_0004;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_causes();
    t_irq();
    t_gate();
    t_div();
    test_done();
  end
endmodule
